// [src/nsd_consts.svh]
// Offsets, field positions, reset values and timing counts of the negative-sequence element
`ifndef NSD_CONSTS_SVH
`define NSD_CONSTS_SVH

`define NSD_OFF_CTRL        8'h00
`define NSD_OFF_ANGLE       8'h04
`define NSD_OFF_MINPOL      8'h08
`define NSD_OFF_STATUS      8'h0C
`define NSD_OFF_STAGE_BASE  8'h10
`define NSD_OFF_STAGE_LAST  8'h4C
`define NSD_SUB_CFG         2'h0
`define NSD_SUB_THR         2'h1
`define NSD_SUB_DELAY       2'h2
`define NSD_SUB_TMS         2'h3

`define NSD_CFG_ENABLE_BIT  0
`define NSD_CFG_DIR_LSB     1
`define NSD_CFG_CURVE_BIT   3

`define NSD_ST_DIR_LSB      0
`define NSD_ST_HEALTH_LSB   2
`define NSD_ST_POLOK_BIT    4
`define NSD_ST_START_LSB    8
`define NSD_ST_TRIP_LSB     12
`define NSD_ST_BLOCK_LSB    16

`define NSD_RST_POLICY      1'h0
`define NSD_RST_ANGLE       8'sh2D
`define NSD_RST_MINPOL      16'h00CD
`define NSD_RST_THR_12      16'h0800
`define NSD_RST_THR_34      16'h0333
`define NSD_RST_DELAY_12    16'h0000
`define NSD_RST_DELAY_34    16'h0190
`define NSD_RST_TMS         16'h0100

`define NSD_PCT_PICK_INV    104
`define NSD_PCT_RELEASE_DT  96
`define NSD_PCT_FULL        100
`define NSD_ANGLE_MAX       90
`define NSD_HYST_SIN2_Q16   498
`define NSD_SQRT3_2_Q15     28378
`define NSD_THIRD_Q15       10923

`define NSD_CLK_PERIOD_NS   5
`define NSD_MS_TIME_NS      1000000
`define NSD_MS_CYCLES       (`NSD_MS_TIME_NS / `NSD_CLK_PERIOD_NS)

`endif

// [src/nsd_pkg.sv]
// Types shared by the negative-sequence directional overcurrent element
package nsd_pkg;

  typedef struct packed {
    logic signed [15:0] re;
    logic signed [15:0] im;
  } nsd_phasor_t;

  // Direction choice and fault direction share one Gray-coded type
  typedef enum logic [1:0] {
    NSD_DIR_NONE = 2'h0,
    NSD_DIR_FWD  = 2'h1,
    NSD_DIR_REV  = 2'h3
  } nsd_dir_t;

  typedef enum logic [1:0] {
    NSD_HEALTH_OK    = 2'h0,
    NSD_HEALTH_WARN  = 2'h1,
    NSD_HEALTH_ALARM = 2'h3
  } nsd_health_t;

  typedef enum logic [1:0] {
    NSD_MODE_OFF     = 2'h0,
    NSD_MODE_ON      = 2'h1,
    NSD_MODE_BLOCKED = 2'h3
  } nsd_mode_t;

  typedef struct packed {
    logic        enable;
    nsd_dir_t    dir_sel;
    logic        inverse;
    logic [15:0] thr;
    logic [15:0] delay_ms;
    logic [15:0] tms;
  } nsd_stage_cfg_t;

  typedef struct packed {
    logic                  policy;
    logic signed [7:0]     angle;
    logic [15:0]           min_pol;
    nsd_stage_cfg_t [3:0]  cfg;
    nsd_dir_t              dir;
    nsd_health_t           health;
    logic                  pol_ok;
    logic [3:0]            pick;
    logic [3:0]            start;
    logic [3:0]            trip;
    logic [3:0]            inh;
    nsd_mode_t [3:0]       mode;
    logic [3:0][15:0]      dt_ms;
    logic [3:0][63:0]      acc;
    logic [31:0]           ms_cnt;
    logic                  ms_tick;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
  } nsd_state_t;

endpackage

// [src/nsd_overcurrent.sv]
// Four-stage negative-sequence overcurrent element with directional supervision and APB registers
`include "nsd_consts.svh"

module nsd_overcurrent
  import nsd_pkg::*;
#(
  parameter int unsigned MS_CYCLES   = `NSD_MS_CYCLES,
  parameter int unsigned INV_K_MS    = 1000
) (
  input  wire logic        CLOCK,
  input  wire logic        RESET,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  nsd_phasor_t      I2_IN,
  input  nsd_phasor_t      UA_IN,
  input  nsd_phasor_t      UB_IN,
  input  nsd_phasor_t      UC_IN,
  input  wire logic        CUR_CH_PRESENT,
  input  wire logic        CUR_CH_THREE_PHASE,
  input  wire logic        VOLT_CH_PRESENT,
  input  wire logic        VOLT_CH_VALID_KIND,
  input  wire logic        VOLT_THREE_INPUTS,
  input  wire logic        VOLTAGE_LOSS_IN,
  input  wire logic        GENERAL_INHIBIT_IN,
  input  wire logic [3:0]  STAGE_INHIBIT_IN,
  output logic      [3:0]  STAGE_START_OUT,
  output logic      [3:0]  STAGE_OPERATE_OUT,
  output logic      [3:0]  STAGE_INHIBITED_OUT,
  output logic      [7:0]  STAGE_OPMODE_OUT,
  output logic      [1:0]  FAULT_DIR_OUT,
  output logic      [1:0]  HEALTH_OUT
);

  nsd_state_t st;
  nsd_state_t next_st;

  function automatic logic [39:0] sq_mag(input nsd_phasor_t p);
    logic signed [31:0] rr;
    logic signed [31:0] ii;
    rr = 32'(p.re) * 32'(p.re);
    ii = 32'(p.im) * 32'(p.im);
    return 40'(unsigned'(rr)) + 40'(unsigned'(ii));
  endfunction

  function automatic logic [39:0] pct_sq(input logic [15:0] thr, input int unsigned pct);
    logic [31:0] scaled;
    scaled = (32'(thr) * 32'(pct)) / 32'(`NSD_PCT_FULL);
    return 40'(scaled) * 40'(scaled);
  endfunction

  // Rational (Bhaskara) sine estimate in Q15; avoids a lookup table at some accuracy cost
  function automatic logic signed [17:0] sin_q15(input logic signed [7:0] deg);
    logic [7:0]  x;
    logic [31:0] p;
    logic [47:0] num;
    logic [31:0] r;
    x = (deg < 0) ? 8'(-deg) : 8'(deg);
    if (x > 8'(`NSD_ANGLE_MAX)) begin
      x = 8'(`NSD_ANGLE_MAX);
    end
    p = 32'(x) * (32'd180 - 32'(x));
    num = 48'(p) << 17;
    r = 32'(num / 48'(32'd40500 - p));
    return (deg < 0) ? -18'(r) : 18'(r);
  endfunction

  // Polarizing voltage and torque term
  logic signed [47:0] u2_re_s;
  logic signed [47:0] u2_im_s;
  nsd_phasor_t        u2;
  logic signed [7:0]  abs_angle;
  logic signed [17:0] cos_t;
  logic signed [17:0] sin_t;
  logic signed [47:0] p_re;
  logic signed [47:0] p_im;
  logic signed [63:0] torque;
  logic [127:0]       torque_sq;
  logic [127:0]       hyst_lim;
  logic [39:0]        isq;
  logic [39:0]        usq;
  logic               pol_now;
  logic               dir_allowed;
  logic               stop_all;

  always_comb begin
    u2_re_s = (48'(UA_IN.re) <<< 15)
            - (48'(48'(UB_IN.re) + 48'(UC_IN.re)) <<< 14)
            + 48'(`NSD_SQRT3_2_Q15) * (48'(UB_IN.im) - 48'(UC_IN.im));
    u2_im_s = (48'(UA_IN.im) <<< 15)
            - (48'(48'(UB_IN.im) + 48'(UC_IN.im)) <<< 14)
            + 48'(`NSD_SQRT3_2_Q15) * (48'(UC_IN.re) - 48'(UB_IN.re));
    u2.re = 16'((u2_re_s * 48'(`NSD_THIRD_Q15)) >>> 30);
    u2.im = 16'((u2_im_s * 48'(`NSD_THIRD_Q15)) >>> 30);
    abs_angle = (st.angle < 0) ? -st.angle : st.angle;
    sin_t = sin_q15(st.angle);
    cos_t = sin_q15(8'(8'sd90 - abs_angle));
    // I2 times conjugate of -U2, rotated by the torque angle
    p_re = 48'(I2_IN.re) * 48'(u2.re) + 48'(I2_IN.im) * 48'(u2.im);
    p_im = 48'(I2_IN.im) * 48'(u2.re) - 48'(I2_IN.re) * 48'(u2.im);
    torque = -((64'(p_re) * 64'(cos_t) + 64'(p_im) * 64'(sin_t)) >>> 15);
    torque_sq = 128'(torque) * 128'(torque);
    isq = sq_mag(I2_IN);
    usq = sq_mag(u2);
    // band of sin(5 deg) times |I2||U2|, compared in squares
    hyst_lim = (128'(isq) * 128'(usq) * 128'(`NSD_HYST_SIN2_Q16)) >> 16;
    // polarization present and not reported lost
    pol_now = (usq > 40'(st.min_pol) * 40'(st.min_pol)) && !VOLTAGE_LOSS_IN;
    // missing or wrong current channel stops the function
    stop_all = !CUR_CH_PRESENT || !CUR_CH_THREE_PHASE;
    // directional stages need a usable voltage channel
    dir_allowed = VOLT_THREE_INPUTS && VOLT_CH_PRESENT && VOLT_CH_VALID_KIND;
  end

  logic [2:0]  stage_sel;
  logic [1:0]  sub_sel;
  logic        addr_hit;
  logic        wr_now;
  logic        any_dir_en;
  logic        eval_dir;
  logic        dir_ok;
  logic        active;
  logic        hi;
  logic        lo;
  logic [39:0] thr_sq;
  logic [63:0] inv_target;
  logic [31:0] rd;

  always_comb begin
    next_st = st;
    stage_sel = 3'(PADDR[6:4] - 3'h1);
    sub_sel = PADDR[3:2];
    rd = 32'h0;
    addr_hit = 1'b1;
    any_dir_en = 1'b0;
    eval_dir = 1'b0;
    dir_ok = 1'b0;
    active = 1'b0;
    hi = 1'b0;
    lo = 1'b0;
    thr_sq = 40'h0;
    inv_target = 64'h0;

    // Millisecond tick paces all stage timers
    next_st.ms_tick = (st.ms_cnt == 32'(MS_CYCLES - 1));
    next_st.ms_cnt = next_st.ms_tick ? 32'h0 : st.ms_cnt + 32'h1;

    // APB slave: one wait state, PREADY registered
    wr_now = PSEL && PENABLE && st.pready && PWRITE;
    case (PADDR)
      `NSD_OFF_CTRL: begin
        rd = 32'(st.policy);
      end
      `NSD_OFF_ANGLE: begin
        rd = 32'(st.angle);
      end
      `NSD_OFF_MINPOL: begin
        rd = 32'(st.min_pol);
      end
      `NSD_OFF_STATUS: begin
        rd[`NSD_ST_DIR_LSB +: 2] = st.dir;
        rd[`NSD_ST_HEALTH_LSB +: 2] = st.health;
        rd[`NSD_ST_POLOK_BIT] = st.pol_ok;
        rd[`NSD_ST_START_LSB +: 4] = st.start;
        rd[`NSD_ST_TRIP_LSB +: 4] = st.trip;
        rd[`NSD_ST_BLOCK_LSB +: 4] = st.inh;
      end
      default: begin
        addr_hit = (PADDR >= `NSD_OFF_STAGE_BASE) && (PADDR <= `NSD_OFF_STAGE_LAST)
                && (PADDR[1:0] == 2'h0);
        if (addr_hit) begin
          case (sub_sel)
            `NSD_SUB_CFG: begin
              rd[`NSD_CFG_ENABLE_BIT] = st.cfg[stage_sel].enable;
              rd[`NSD_CFG_DIR_LSB +: 2] = st.cfg[stage_sel].dir_sel;
              rd[`NSD_CFG_CURVE_BIT] = st.cfg[stage_sel].inverse;
            end
            `NSD_SUB_THR: begin
              rd = 32'(st.cfg[stage_sel].thr);
            end
            `NSD_SUB_DELAY: begin
              rd = 32'(st.cfg[stage_sel].delay_ms);
            end
            default: begin
              rd = 32'(st.cfg[stage_sel].tms);
            end
          endcase
        end
      end
    endcase
    if (PADDR[1:0] != 2'h0) begin
      addr_hit = 1'b0;
      rd = 32'h0;
    end
    next_st.pready = PSEL && PENABLE && !st.pready;
    next_st.prdata = (next_st.pready && !PWRITE && addr_hit) ? rd : 32'h0;
    next_st.pslverr = next_st.pready && !addr_hit;
    if (wr_now && addr_hit) begin
      case (PADDR)
        `NSD_OFF_CTRL: begin
          // policy bit: 0 trips non-directionally, 1 blocks
          next_st.policy = PWDATA[0];
        end
        `NSD_OFF_ANGLE: begin
          next_st.angle = PWDATA[7:0];
        end
        `NSD_OFF_MINPOL: begin
          next_st.min_pol = PWDATA[15:0];
        end
        `NSD_OFF_STATUS: begin
          next_st.policy = st.policy;
        end
        default: begin
          case (sub_sel)
            `NSD_SUB_CFG: begin
              next_st.cfg[stage_sel].enable = PWDATA[`NSD_CFG_ENABLE_BIT];
              // direction choice per stage; value 2 reads as non-directional
              case (PWDATA[`NSD_CFG_DIR_LSB +: 2])
                2'h1: next_st.cfg[stage_sel].dir_sel = NSD_DIR_FWD;
                2'h3: next_st.cfg[stage_sel].dir_sel = NSD_DIR_REV;
                default: next_st.cfg[stage_sel].dir_sel = NSD_DIR_NONE;
              endcase
              // inverse curve only on stages 3 and 4
              next_st.cfg[stage_sel].inverse = PWDATA[`NSD_CFG_CURVE_BIT] && stage_sel[1];
            end
            `NSD_SUB_THR: begin
              next_st.cfg[stage_sel].thr = PWDATA[15:0];
            end
            `NSD_SUB_DELAY: begin
              next_st.cfg[stage_sel].delay_ms = PWDATA[15:0];
            end
            default: begin
              next_st.cfg[stage_sel].tms = PWDATA[15:0];
            end
          endcase
        end
      endcase
    end

    if (stop_all) begin
      next_st.health = NSD_HEALTH_ALARM;
    end else if (!dir_allowed) begin
      next_st.health = NSD_HEALTH_WARN;
    end else begin
      next_st.health = NSD_HEALTH_OK;
    end
    next_st.pol_ok = pol_now;

    // direction is only looked at while a directional stage sees overcurrent
    for (int i = 0; i < 4; i++) begin
      if (st.cfg[i].enable && st.cfg[i].dir_sel != NSD_DIR_NONE && dir_allowed) begin
        any_dir_en = 1'b1;
        if (isq > pct_sq(st.cfg[i].thr, `NSD_PCT_FULL)) begin
          eval_dir = 1'b1;
        end
      end
    end

    // unknown when nothing directional or no fault; hysteresis per state
    if (!any_dir_en || !eval_dir || !pol_now || stop_all) begin
      next_st.dir = NSD_DIR_NONE;
    end else begin
      case (st.dir)
        NSD_DIR_FWD: begin
          if (torque < 0 && torque_sq > hyst_lim) begin
            next_st.dir = NSD_DIR_REV;
          end
        end
        NSD_DIR_REV: begin
          if (torque > 0 && torque_sq > hyst_lim) begin
            next_st.dir = NSD_DIR_FWD;
          end
        end
        default: begin
          // positive torque means flow into the protected object
          if (torque > 0) begin
            next_st.dir = NSD_DIR_FWD;
          end else if (torque < 0) begin
            next_st.dir = NSD_DIR_REV;
          end else begin
            next_st.dir = NSD_DIR_NONE;
          end
        end
      endcase
    end

    for (int i = 0; i < 4; i++) begin
      next_st.inh[i] = STAGE_INHIBIT_IN[i] || GENERAL_INHIBIT_IN;
      // lost polarization: trip policy ignores direction, block policy stops
      if (st.cfg[i].dir_sel == NSD_DIR_NONE) begin
        dir_ok = 1'b1;
      end else if (!dir_allowed) begin
        dir_ok = 1'b0;
      end else if (!pol_now) begin
        dir_ok = !st.policy;
      end else begin
        // decided direction must match the stage choice
        dir_ok = (st.dir == st.cfg[i].dir_sel);
      end
      active = st.cfg[i].enable && !next_st.inh[i] && !stop_all;
      // definite start and 96 percent release; inverse uses 104 and 100 percent
      thr_sq = pct_sq(st.cfg[i].thr, `NSD_PCT_FULL);
      if (st.cfg[i].inverse) begin
        hi = isq > pct_sq(st.cfg[i].thr, `NSD_PCT_PICK_INV);
        lo = isq < thr_sq;
      end else begin
        hi = isq > thr_sq;
        lo = isq < pct_sq(st.cfg[i].thr, `NSD_PCT_RELEASE_DT);
      end
      if (!active || lo) begin
        next_st.pick[i] = 1'b0;
      end else if (hi) begin
        next_st.pick[i] = 1'b1;
      end
      next_st.start[i] = next_st.pick[i] && dir_ok;
      inv_target = (64'(thr_sq) * 64'(st.cfg[i].tms) * 64'(INV_K_MS)) >> 8;
      if (!next_st.start[i]) begin
        next_st.dt_ms[i] = 16'h0;
        next_st.acc[i] = 64'h0;
        next_st.trip[i] = 1'b0;
      end else if (st.cfg[i].inverse) begin
        // Accumulates (I2^2 - Iop^2) so time goes as TM*K/((I/Iop)^2 - 1)
        if (st.ms_tick && !st.trip[i]) begin
          next_st.acc[i] = st.acc[i] + 64'(isq - thr_sq);
        end
        next_st.trip[i] = next_st.acc[i] >= inv_target;
      end else begin
        // fixed delay, zero operates together with start
        if (st.ms_tick && !st.trip[i] && st.dt_ms[i] != 16'hFFFF) begin
          next_st.dt_ms[i] = st.dt_ms[i] + 16'h1;
        end
        next_st.trip[i] = next_st.dt_ms[i] >= st.cfg[i].delay_ms;
      end
      if (!st.cfg[i].enable || stop_all) begin
        next_st.mode[i] = NSD_MODE_OFF;
      end else if (next_st.inh[i]) begin
        next_st.mode[i] = NSD_MODE_BLOCKED;
      end else begin
        next_st.mode[i] = NSD_MODE_ON;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      st <= '0;
      st.policy <= `NSD_RST_POLICY;
      st.angle <= `NSD_RST_ANGLE;
      st.min_pol <= `NSD_RST_MINPOL;
      for (int i = 0; i < 4; i++) begin
        st.cfg[i].thr <= (i < 2) ? `NSD_RST_THR_12 : `NSD_RST_THR_34;
        st.cfg[i].delay_ms <= (i < 2) ? `NSD_RST_DELAY_12 : `NSD_RST_DELAY_34;
        st.cfg[i].tms <= `NSD_RST_TMS;
      end
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  always_comb begin
    PRDATA = st.prdata;
    PREADY = st.pready;
    PSLVERR = st.pslverr;
    STAGE_START_OUT = st.start;
    STAGE_OPERATE_OUT = st.trip;
    STAGE_INHIBITED_OUT = st.inh;
    STAGE_OPMODE_OUT = st.mode;
    FAULT_DIR_OUT = st.dir;
    HEALTH_OUT = st.health;
  end

endmodule

// [test/nsd_overcurrent_props.sv]
// Concurrent checks on blocking, health, direction and bus outputs
module nsd_overcurrent_props import nsd_pkg::*; (
  input wire logic       CLOCK,
  input wire logic       RESET,
  input wire logic       PREADY,
  input wire logic       CUR_CH_PRESENT,
  input wire logic       CUR_CH_THREE_PHASE,
  input wire logic       VOLT_CH_VALID_KIND,
  input wire logic       VOLTAGE_LOSS_IN,
  input wire logic       GENERAL_INHIBIT_IN,
  input wire logic [3:0] STAGE_START_OUT,
  input wire logic [3:0] STAGE_OPERATE_OUT,
  input wire logic [3:0] STAGE_INHIBITED_OUT,
  input wire logic [1:0] FAULT_DIR_OUT,
  input wire logic [1:0] HEALTH_OUT
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);

  a_inhibit_flags: assert property (
    GENERAL_INHIBIT_IN |=> STAGE_INHIBITED_OUT == 4'hF)
    else $error("general inhibit not flagged on all stages");
  a_inhibit_quiet: assert property (
    (STAGE_START_OUT & STAGE_INHIBITED_OUT) == 4'h0)
    else $error("inhibited stage shows start");
  a_operate_start: assert property (
    (STAGE_OPERATE_OUT & ~STAGE_START_OUT) == 4'h0)
    else $error("operate without start");
  a_alarm_health: assert property (
    !(CUR_CH_PRESENT && CUR_CH_THREE_PHASE)
    |=> HEALTH_OUT == NSD_HEALTH_ALARM && STAGE_START_OUT == 4'h0)
    else $error("current channel fault not alarmed");
  a_warn_health: assert property (
    CUR_CH_PRESENT && CUR_CH_THREE_PHASE && !VOLT_CH_VALID_KIND
    |=> HEALTH_OUT == NSD_HEALTH_WARN)
    else $error("voltage channel fault not warned");
  a_loss_unknown: assert property (
    VOLTAGE_LOSS_IN |=> FAULT_DIR_OUT == NSD_DIR_NONE)
    else $error("direction decided without polarization");
  a_dir_legal: assert property (FAULT_DIR_OUT != 2'h2)
    else $error("illegal fault direction code");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held longer than one cycle");
endmodule

bind nsd_overcurrent nsd_overcurrent_props nsd_overcurrent_props_inst (
  .CLOCK(CLOCK), .RESET(RESET), .PREADY(PREADY), .CUR_CH_PRESENT(CUR_CH_PRESENT),
  .CUR_CH_THREE_PHASE(CUR_CH_THREE_PHASE), .VOLT_CH_VALID_KIND(VOLT_CH_VALID_KIND),
  .VOLTAGE_LOSS_IN(VOLTAGE_LOSS_IN), .GENERAL_INHIBIT_IN(GENERAL_INHIBIT_IN),
  .STAGE_START_OUT(STAGE_START_OUT), .STAGE_OPERATE_OUT(STAGE_OPERATE_OUT),
  .STAGE_INHIBITED_OUT(STAGE_INHIBITED_OUT), .FAULT_DIR_OUT(FAULT_DIR_OUT),
  .HEALTH_OUT(HEALTH_OUT));

// [test/nsd_phasor_src.sv]
// Analogue source model: pure negative-sequence current and voltage phasors
module nsd_phasor_src import nsd_pkg::*; (
  input  wire logic signed [15:0] cur_mag,
  input  wire logic signed [15:0] volt_mag,
  output nsd_phasor_t             i2,
  output nsd_phasor_t             ua,
  output nsd_phasor_t             ub,
  output nsd_phasor_t             uc
);
  logic signed [31:0] h;
  assign i2 = '{re: cur_mag, im: 16'sh0000};
  // phases set so U2 is minus volt_mag
  assign h  = (32'(volt_mag) * 32'sh0000_6EDA) >>> 15;
  assign ua = '{re: -volt_mag, im: 16'sh0000};
  assign ub = '{re: volt_mag >>> 1, im: -h[15:0]};
  assign uc = '{re: volt_mag >>> 1, im: h[15:0]};
endmodule

// [test/nsd_overcurrent_tb_top.sv]
// Bench: register rows, then direction, blocking, health and delay cases
module nsd_overcurrent_tb_top import nsd_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] data;
    logic        err;
  } nsd_row_t;
  localparam int MS = 10;
  logic               clock = 1'b0;
  logic               reset = 1'b1;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic signed [15:0] cur = 16'sh0;
  logic signed [15:0] volt = 16'sh0;
  logic [5:0]         sense = 6'h3E;
  logic               gen_inh = 1'b0;
  logic [3:0]         stg_inh = 4'h0;
  logic [3:0]         start, oper, inh_out;
  logic [7:0]         opmode;
  logic [1:0]         dir, health;
  nsd_phasor_t        i2, ua, ub, uc;
  int                 failures = 0;
  int                 check_count = 0;
  int                 cycles = 0;
  nsd_row_t rows [17] = '{
    '{1'b0, 8'h00, 32'h0, 1'b0}, '{1'b0, 8'h04, 32'h2D, 1'b0},
    '{1'b0, 8'h08, 32'hCD, 1'b0}, '{1'b0, 8'h14, 32'h800, 1'b0},
    '{1'b0, 8'h24, 32'h800, 1'b0}, '{1'b0, 8'h18, 32'h0, 1'b0},
    '{1'b0, 8'h28, 32'h0, 1'b0}, '{1'b0, 8'h3C, 32'h100, 1'b0},
    '{1'b0, 8'h10, 32'h0, 1'b0}, '{1'b0, 8'h50, 32'h0, 1'b1},
    '{1'b1, 8'h52, 32'h1, 1'b1}, '{1'b1, 8'h10, 32'h5, 1'b0},
    '{1'b0, 8'h10, 32'h1, 1'b0}, '{1'b1, 8'h30, 32'hF, 1'b0},
    '{1'b0, 8'h30, 32'hF, 1'b0}, '{1'b1, 8'h10, 32'h9, 1'b0},
    '{1'b0, 8'h10, 32'h1, 1'b0}};

  nsd_overcurrent #(.MS_CYCLES(MS)) nsd_overcurrent_inst (
    .CLOCK(clock), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .I2_IN(i2), .UA_IN(ua), .UB_IN(ub), .UC_IN(uc), .CUR_CH_PRESENT(sense[5]),
    .CUR_CH_THREE_PHASE(sense[4]), .VOLT_CH_PRESENT(sense[3]),
    .VOLT_CH_VALID_KIND(sense[2]), .VOLT_THREE_INPUTS(sense[1]),
    .VOLTAGE_LOSS_IN(sense[0]), .GENERAL_INHIBIT_IN(gen_inh), .STAGE_INHIBIT_IN(stg_inh),
    .STAGE_START_OUT(start), .STAGE_OPERATE_OUT(oper), .STAGE_INHIBITED_OUT(inh_out),
    .STAGE_OPMODE_OUT(opmode), .FAULT_DIR_OUT(dir), .HEALTH_OUT(health));
  nsd_phasor_src nsd_phasor_src_inst (
    .cur_mag(cur), .volt_mag(volt), .i2(i2), .ua(ua), .ub(ub), .uc(uc));

  always #2.5 clock = ~clock;

  task automatic test_done();
    if (failures == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Run is a few hundred cycles; a hang stops here
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      test_done();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask

  // Request held until ready is sampled high
  task automatic apb(input nsd_row_t r);
    psel <= 1'b1;
    pwrite <= r.wr;
    paddr <= r.addr;
    pwdata <= r.data;
    @(posedge clock);
    penable <= 1'b1;
    // No limit of its own; a hang here is ended by the bench timeout
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    check({31'h0, pready}, 32'h1);
    check({31'h0, pslverr}, {31'h0, r.err});
    if (!r.wr) check(prdata, r.data);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb('{1'b1, a, d, 1'b0});
  endtask

  task automatic drive(input logic signed [15:0] c, input logic signed [15:0] v);
    cur <= c;
    volt <= v;
    repeat (6) @(posedge clock);
  endtask

  task automatic see(input logic [3:0] s, input logic [1:0] d);
    check({28'h0, start}, {28'h0, s});
    check({30'h0, dir}, {30'h0, d});
  endtask

  initial begin
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    foreach (rows[k]) apb(rows[k]);
    wr(8'h10, 32'h1);
    wr(8'h20, 32'h3);
    wr(8'h30, 32'h7);
    wr(8'h38, 32'h0);
    drive(16'sh1000, 16'sh0000);
    see(4'h7, NSD_DIR_NONE);
    check({31'h0, oper[0]}, 32'h1);
    drive(16'sh07C0, 16'sh0000);
    check({31'h0, start[0]}, 32'h1);
    drive(16'sh0790, 16'sh0000);
    check({31'h0, start[0]}, 32'h0);
    drive(16'sh1000, 16'sh0800);
    see(4'h3, NSD_DIR_FWD);
    drive(-16'sh1000, 16'sh0800);
    see(4'h5, NSD_DIR_REV);
    sense[0] <= 1'b1;
    drive(16'sh1000, 16'sh0800);
    see(4'h7, NSD_DIR_NONE);
    wr(8'h00, 32'h1);
    drive(16'sh1000, 16'sh0800);
    see(4'h1, NSD_DIR_NONE);
    sense[0] <= 1'b0;
    drive(16'sh1000, 16'sh0000);
    see(4'h1, NSD_DIR_NONE);
    wr(8'h00, 32'h0);
    wr(8'h20, 32'h1);
    wr(8'h30, 32'h1);
    drive(16'sh1000, 16'sh0800);
    see(4'h7, NSD_DIR_NONE);
    wr(8'h20, 32'h3);
    wr(8'h30, 32'h7);
    gen_inh <= 1'b1;
    drive(16'sh1000, 16'sh0800);
    check({28'h0, inh_out}, 32'hF);
    check({30'h0, opmode[1:0]}, 32'h3);
    gen_inh <= 1'b0;
    stg_inh <= 4'h2;
    drive(16'sh1000, 16'sh0800);
    check({24'h0, inh_out, start}, 32'h21);
    check({30'h0, opmode[1:0]}, 32'h1);
    stg_inh <= 4'h0;
    sense[4] <= 1'b0;
    drive(16'sh1000, 16'sh0800);
    check({26'h0, health, start}, 32'h30);
    sense[4] <= 1'b1;
    sense[2] <= 1'b0;
    drive(16'sh1000, 16'sh0800);
    check({26'h0, health, start}, 32'h11);
    sense[2] <= 1'b1;
    sense[1] <= 1'b0;
    drive(16'sh1000, 16'sh0800);
    check({28'h0, start}, 32'h1);
    sense[1] <= 1'b1;
    // Torque angle of 90 degrees leaves in-phase quantities on the boundary
    wr(8'h04, 32'h5A);
    drive(16'sh0000, 16'sh0800);
    drive(16'sh1000, 16'sh0800);
    see(4'h1, NSD_DIR_NONE);
    wr(8'h04, 32'h2D);
    wr(8'h18, 32'h2);
    drive(16'sh0000, 16'sh0800);
    drive(16'sh1000, 16'sh0800);
    check({26'h0, health, start}, 32'h03);
    check({31'h0, oper[0]}, 32'h0);
    // Two ms of ticks plus up to one tick of phase
    repeat (3 * MS) @(posedge clock);
    check({31'h0, oper[0]}, 32'h1);
    apb('{1'b0, 8'h0C, 32'h3311, 1'b0});
    // Mid-run reset must clear outputs and restore the defaults
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    check({8'h0, opmode, health, dir, oper, start, inh_out}, 32'h0);
    apb('{1'b0, 8'h10, 32'h0, 1'b0});
    apb('{1'b0, 8'h18, 32'h0, 1'b0});
    test_done();
  end
endmodule
